// file: asm_defines.svh
`ifndef ASM_DEFINES_SVH
`define ASM_DEFINES_SVH

// ----------------------------------------------------------------
// serial command codes and register addresses
// ----------------------------------------------------------------
`define ASM_CMD_RESET 8'h01
`define ASM_REG_CFG 8'hb2
`define ASM_REG_THR 8'hb3
`define ASM_REG_RESULT 8'hb4
`define ASM_REG_PWR 8'hc0
`define ASM_REG_STATUS 8'hc6

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define ASM_CFG_RESET 16'h0000
`define ASM_THR_RESET 16'hff00
`define ASM_PWR_RESET 16'h0002
`define ASM_ST_HIGH 0
`define ASM_ST_LOW 1
`define ASM_ADDR_BITS 8
`define ASM_DATA_BITS 16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASM_CLK_PERIOD_PS 5000
`define ASM_POR_CYCLES 256
`define ASM_INTERVAL_NS 20800
`define ASM_INTERVAL_CYCLES (`ASM_INTERVAL_NS * 1000 / `ASM_CLK_PERIOD_PS)
`define ASM_WAKE_US 400
`define ASM_WAKE_CYCLES (`ASM_WAKE_US * 1000000 / `ASM_CLK_PERIOD_PS)
`define ASM_SAR_STEP_CYCLES 8

`endif

// file: asm_pkg.sv
`default_nettype none
package asm_pkg;

  typedef enum logic [1:0] {
    SRC_MONITOR = 2'b00,
    SRC_MIC_ONE = 2'b01,
    SRC_INPUT_TWO = 2'b10,
    SRC_DISC = 2'b11
  } asm_src_t;

  typedef struct packed {
    logic [7:0] interval;
    logic [1:0] spare;
    logic wake_tx;
    logic wake_en;
    logic lo_irq_en;
    logic hi_irq_en;
    asm_src_t src;
  } asm_cfg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } asm_thr_t;

  typedef struct packed {
    logic [10:0] spare;
    logic tx_en;
    logic rx_en;
    logic adc_en;
    logic xtal_en;
    logic bias_en;
  } asm_pwr_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b11,
    BUS_END = 2'b10
  } asm_bus_state_t;

endpackage : asm_pkg
`default_nettype wire

// file: asm_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "asm_defines.svh"

module asm_monitor
  import asm_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = `ASM_INTERVAL_CYCLES
) (
  input wire logic clk, // 200 MHz clock
  input wire logic reset_n, // async reset, power present
  input wire logic cbus_csn_n, // serial select, low active
  input wire logic cbus_sclk, // serial clock from host
  input wire logic cbus_cdata, // serial command data in
  output logic cbus_rdata, // serial reply data out
  output logic cbus_rdata_oe, // reply pin driven
  input wire logic sar_cmp, // input at or above trial code
  output logic [7:0] sar_dac_code, // trial code to comparator
  output asm_src_t adc_src_sel, // selected monitor input
  output asm_pwr_t power_ctl, // block power enables
  output logic por_active, // internal reset held
  output logic host_interrupt_n // interrupt to host, low active
);

  // ----------------------------------------------------------------
  // internal reset
  // ----------------------------------------------------------------
  logic por_busy_reg;
  logic [8:0] por_cnt_reg;
  logic soft_rst;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      por_busy_reg <= 1'b1;
      por_cnt_reg <= 9'h000;
    end else if (soft_rst) begin
      por_busy_reg <= 1'b1;
      por_cnt_reg <= 9'h000;
    end else if (por_busy_reg) begin
      por_busy_reg <= (por_cnt_reg != 9'(`ASM_POR_CYCLES - 1));
      por_cnt_reg <= por_cnt_reg + 9'h001;
    end
  end
  assign por_active = por_busy_reg;

  // ----------------------------------------------------------------
  // serial host port
  // ----------------------------------------------------------------
  asm_bus_state_t bus_state_reg;
  logic sclk_q_reg;
  logic [3:0] bit_cnt_reg;
  logic [15:0] sh_reg;
  logic [15:0] rd_sh_reg;
  logic [7:0] addr_reg;
  logic rdata_reg;
  logic rdata_oe_reg;
  asm_cfg_t cfg_reg;
  asm_thr_t thr_reg;
  asm_pwr_t pwr_reg;
  logic [7:0] result_reg;
  logic [1:0] status_reg;

  wire sclk_rise = cbus_sclk & ~sclk_q_reg;
  wire sclk_fall = ~cbus_sclk & sclk_q_reg;
  wire bus_live = ~cbus_csn_n & ~por_busy_reg;
  wire [7:0] addr_in = {sh_reg[6:0], cbus_cdata};
  wire [15:0] data_in = {sh_reg[14:0], cbus_cdata};
  wire addr_done = bus_live & sclk_rise & (bus_state_reg == BUS_ADDR)
                   & (bit_cnt_reg == 4'(`ASM_ADDR_BITS - 1));
  wire data_done = bus_live & sclk_rise & (bus_state_reg == BUS_DATA)
                   & (bit_cnt_reg == 4'(`ASM_DATA_BITS - 1));
  wire is_read = (addr_in == `ASM_REG_RESULT)
                 | (addr_in == `ASM_REG_STATUS);
  wire wr_cfg = data_done & (addr_reg == `ASM_REG_CFG);
  wire wr_thr = data_done & (addr_reg == `ASM_REG_THR);
  wire wr_pwr = data_done & (addr_reg == `ASM_REG_PWR);
  wire rd_status = addr_done & (addr_in == `ASM_REG_STATUS);
  assign soft_rst = addr_done & (addr_in == `ASM_CMD_RESET);

  function automatic logic [15:0] read_mux(input logic [7:0] a,
                                           input logic [7:0] res,
                                           input logic [1:0] st);
    if (a == `ASM_REG_RESULT) read_mux = {8'h00, res};
    else if (a == `ASM_REG_STATUS) read_mux = {14'h0000, st};
    else read_mux = 16'h0000;
  endfunction : read_mux

  wire [15:0] rd_word = read_mux(addr_in, result_reg, status_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sclk_q_reg <= 1'b0;
    else sclk_q_reg <= cbus_sclk;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state_reg <= BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 16'h0000;
      addr_reg <= 8'h00;
    end else if (!bus_live) begin
      bus_state_reg <= cbus_csn_n ? BUS_IDLE : BUS_END;
      bit_cnt_reg <= 4'h0;
    end else begin
      if (bus_state_reg == BUS_IDLE) bus_state_reg <= BUS_ADDR;
      if (sclk_rise) begin
        sh_reg <= data_in;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (addr_done) begin
        addr_reg <= addr_in;
        bit_cnt_reg <= 4'h0;
        bus_state_reg <= (addr_in == `ASM_CMD_RESET) ? BUS_END : BUS_DATA;
      end
      if (data_done) bus_state_reg <= BUS_END;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_sh_reg <= 16'h0000;
      rdata_reg <= 1'b0;
      rdata_oe_reg <= 1'b0;
    end else if (!bus_live) begin
      rdata_oe_reg <= 1'b0;
    end else if (addr_done) begin
      rd_sh_reg <= rd_word;
      rdata_reg <= rd_word[15];
      rdata_oe_reg <= is_read;
    end else if (sclk_fall && bus_state_reg == BUS_DATA) begin
      rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
      rdata_reg <= rd_sh_reg[14];
    end
  end
  assign cbus_rdata = rdata_reg;
  assign cbus_rdata_oe = rdata_oe_reg;

  // ----------------------------------------------------------------
  // option registers
  // ----------------------------------------------------------------
  logic hi_evt;
  logic lo_evt;
  wire wake_req = hi_evt & cfg_reg.wake_en;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `ASM_CFG_RESET;
      thr_reg <= `ASM_THR_RESET;
    end else if (por_busy_reg) begin
      cfg_reg <= `ASM_CFG_RESET;
      thr_reg <= `ASM_THR_RESET;
    end else begin
      if (wr_cfg) cfg_reg <= data_in;
      if (wr_thr) thr_reg <= data_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_reg <= `ASM_PWR_RESET;
    end else if (por_busy_reg) begin
      pwr_reg <= {pwr_reg[15:2], pwr_reg.xtal_en, 1'b0};
      pwr_reg.adc_en <= 1'b0;
      pwr_reg.rx_en <= 1'b0;
      pwr_reg.tx_en <= 1'b0;
    end else begin
      if (wr_pwr) pwr_reg <= data_in;
      if (wake_req) begin
        pwr_reg.bias_en <= 1'b1;
        if (cfg_reg.wake_tx) pwr_reg.tx_en <= 1'b1;
        else pwr_reg.rx_en <= 1'b1;
      end
    end
  end
  assign power_ctl = pwr_reg;
  assign adc_src_sel = cfg_reg.src;

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  wire run_ok = pwr_reg.adc_en & pwr_reg.bias_en & pwr_reg.xtal_en
                & ~por_busy_reg;
  logic [15:0] base_cnt_reg;
  logic [7:0] mult_cnt_reg;
  logic [2:0] step_cnt_reg;
  logic sar_busy_reg;
  logic [2:0] sar_idx_reg;
  logic [7:0] trial_reg;
  logic done_reg;

  wire base_tick = base_cnt_reg == 16'(INTERVAL_CYCLES - 1);
  wire conv_start = run_ok & base_tick
                    & (mult_cnt_reg == cfg_reg.interval) & ~sar_busy_reg;
  wire step_en = step_cnt_reg == 3'(`ASM_SAR_STEP_CYCLES - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_cnt_reg <= 16'h0000;
      mult_cnt_reg <= 8'h00;
    end else if (!run_ok) begin
      base_cnt_reg <= 16'h0000;
      mult_cnt_reg <= 8'h00;
    end else if (base_tick) begin
      base_cnt_reg <= 16'h0000;
      mult_cnt_reg <= (mult_cnt_reg == cfg_reg.interval) ? 8'h00
                      : mult_cnt_reg + 8'h01;
    end else begin
      base_cnt_reg <= base_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) step_cnt_reg <= 3'h0;
    else if (!sar_busy_reg) step_cnt_reg <= 3'h0;
    else step_cnt_reg <= step_cnt_reg + 3'h1;
  end

  // ----------------------------------------------------------------
  // successive approximation
  // ----------------------------------------------------------------
  wire [7:0] bit_sel = 8'h01 << sar_idx_reg;
  wire [7:0] kept = sar_cmp ? trial_reg : (trial_reg & ~bit_sel);
  wire last_step = sar_busy_reg & step_en & (sar_idx_reg == 3'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sar_busy_reg <= 1'b0;
      sar_idx_reg <= 3'h7;
      trial_reg <= 8'h00;
      result_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= last_step & run_ok;
      if (!run_ok) begin
        sar_busy_reg <= 1'b0;
      end else if (conv_start) begin
        sar_busy_reg <= 1'b1;
        sar_idx_reg <= 3'h7;
        trial_reg <= 8'h80;
      end else if (sar_busy_reg && step_en) begin
        if (sar_idx_reg == 3'h0) begin
          sar_busy_reg <= 1'b0;
          trial_reg <= kept;
          result_reg <= kept;
        end else begin
          trial_reg <= kept | (bit_sel >> 1);
          sar_idx_reg <= sar_idx_reg - 3'h1;
        end
      end
    end
  end
  assign sar_dac_code = trial_reg;

  // ----------------------------------------------------------------
  // threshold compare and interrupt
  // ----------------------------------------------------------------
  logic above_hi_reg;
  logic below_lo_reg;
  logic irq_n_reg;
  wire hi_now = result_reg > thr_reg.high;
  wire lo_now = result_reg < thr_reg.low;
  assign hi_evt = done_reg & hi_now & ~above_hi_reg;
  assign lo_evt = done_reg & lo_now & ~below_lo_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      above_hi_reg <= 1'b0;
      below_lo_reg <= 1'b0;
    end else if (por_busy_reg) begin
      above_hi_reg <= 1'b0;
      below_lo_reg <= 1'b0;
    end else if (done_reg) begin
      above_hi_reg <= hi_now;
      below_lo_reg <= lo_now;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= 2'b00;
    end else if (por_busy_reg) begin
      status_reg <= 2'b00;
    end else begin
      // set beats the read clear
      status_reg[`ASM_ST_HIGH] <= hi_evt
        | (status_reg[`ASM_ST_HIGH] & ~rd_status);
      status_reg[`ASM_ST_LOW] <= lo_evt
        | (status_reg[`ASM_ST_LOW] & ~rd_status);
    end
  end

  wire [1:0] irq_mask = {cfg_reg.lo_irq_en, cfg_reg.hi_irq_en};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) irq_n_reg <= 1'b1;
    else irq_n_reg <= ~|(status_reg & irq_mask);
  end
  assign host_interrupt_n = irq_n_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [9:0] hold_cnt_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hold_cnt_reg <= 10'h000;
    else if (soft_rst) hold_cnt_reg <= 10'h000;
    else if (por_busy_reg) hold_cnt_reg <= hold_cnt_reg + 10'h001;
    else hold_cnt_reg <= 10'h000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_por_len;
    $fell(por_busy_reg) |-> hold_cnt_reg == 10'h100;
  endproperty
  a_por_len: assert property (p_por_len) else $error("reset hold length");
  property p_soft_rst;
    soft_rst |=> por_busy_reg [*8];
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset");
  property p_sleep;
    $fell(por_busy_reg) |-> !pwr_reg.adc_en && !pwr_reg.rx_en
      && !pwr_reg.tx_en && !pwr_reg.bias_en && cfg_reg.interval == 8'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("not asleep");
  property p_xtal;
    $fell(pwr_reg.xtal_en) |-> $past(wr_pwr);
  endproperty
  a_xtal: assert property (p_xtal) else $error("xtal off");
  property p_wake;
    hi_evt && cfg_reg.wake_en && !cfg_reg.wake_tx |=> pwr_reg.rx_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_gate;
    $rose(sar_busy_reg) |-> $past(pwr_reg.adc_en && pwr_reg.bias_en
      && pwr_reg.xtal_en);
  endproperty
  a_gate: assert property (p_gate) else $error("ran unpowered");
  property p_irq;
    hi_evt && cfg_reg.hi_irq_en ##1 cfg_reg.hi_irq_en |=> !host_interrupt_n;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_once_hi;
    hi_evt |-> !above_hi_reg ##1 above_hi_reg;
  endproperty
  a_once_hi: assert property (p_once_hi) else $error("repeat high");
  property p_lo;
    lo_evt |-> result_reg < thr_reg.low ##1 status_reg[`ASM_ST_LOW];
  endproperty
  a_lo: assert property (p_lo) else $error("low event");
  property p_mask;
    !host_interrupt_n |-> $past(|(status_reg & irq_mask));
  endproperty
  a_mask: assert property (p_mask) else $error("unmasked irq");

  c_high: cover property (hi_evt && cfg_reg.wake_en);
  c_low: cover property (lo_evt);
  c_soft: cover property (soft_rst);
  c_read: cover property (rd_status && status_reg != 2'b00);

endmodule : asm_monitor
`default_nettype wire

// file: asm_analog_src.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// comparator model: four input levels against the trial code
// ----------------------------------------------------------------
module asm_analog_src
  import asm_pkg::*;
(
  input wire logic [7:0] lvl_monitor, // signal monitor pin level
  input wire logic [7:0] lvl_mic_one, // microphone input one level
  input wire logic [7:0] lvl_input_two, // second input level
  input wire logic [7:0] lvl_disc, // discriminator input level
  input wire logic [7:0] sar_dac_code, // trial code from converter
  input wire asm_src_t adc_src_sel, // selected input
  output logic sar_cmp // selected level at or above code
);
  logic [7:0] sel_lvl;

  always_comb begin
    case (adc_src_sel)
      SRC_MONITOR: sel_lvl = lvl_monitor;
      SRC_MIC_ONE: sel_lvl = lvl_mic_one;
      SRC_INPUT_TWO: sel_lvl = lvl_input_two;
      default: sel_lvl = lvl_disc;
    endcase
  end

  assign sar_cmp = (sel_lvl >= sar_dac_code);
endmodule : asm_analog_src
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  import asm_pkg::*;
  logic clk, reset_n, cbus_csn_n, cbus_sclk, cbus_cdata;
  logic cbus_rdata, cbus_rdata_oe, sar_cmp, por_active, host_interrupt_n;
  logic [7:0] sar_dac_code;
  logic [7:0] lvl [4];
  asm_src_t adc_src_sel;
  asm_pwr_t power_ctl;
  int errors = 0;
  int tests_run = 0;
  logic [15:0] rd;
  logic oe;
  int n;

  asm_monitor #(.INTERVAL_CYCLES(16)) u_asm_monitor (
    .clk(clk), .reset_n(reset_n), .cbus_csn_n(cbus_csn_n),
    .cbus_sclk(cbus_sclk), .cbus_cdata(cbus_cdata),
    .cbus_rdata(cbus_rdata), .cbus_rdata_oe(cbus_rdata_oe),
    .sar_cmp(sar_cmp), .sar_dac_code(sar_dac_code),
    .adc_src_sel(adc_src_sel), .power_ctl(power_ctl),
    .por_active(por_active), .host_interrupt_n(host_interrupt_n));

  asm_analog_src u_asm_analog_src (
    .lvl_monitor(lvl[0]), .lvl_mic_one(lvl[1]), .lvl_input_two(lvl[2]),
    .lvl_disc(lvl[3]), .sar_dac_code(sar_dac_code),
    .adc_src_sel(adc_src_sel), .sar_cmp(sar_cmp));

  // ----------------------------------------------------------------
  // clock, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #400000;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic clks(input int k);
    repeat (k) @(negedge clk);
  endtask : clks

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one frame: address, then nd data bits; reply sampled before each fall
  task automatic xfer(input logic [7:0] a, input logic [15:0] wd,
                      input int nd, output logic [15:0] rdat,
                      output logic oe_seen);
    rdat = 16'h0000;
    oe_seen = 1'b0;
    cbus_csn_n = 1'b0;
    clks(2);
    for (int i = 7; i >= 0; i--) begin
      cbus_cdata = a[i];
      cbus_sclk = 1'b0;
      clks(2);
      cbus_sclk = 1'b1;
      clks(2);
    end
    for (int i = 15; i >= 16 - nd; i--) begin
      rdat[i] = cbus_rdata;
      if (i == 15) begin
        oe_seen = cbus_rdata_oe;
      end
      cbus_sclk = 1'b0;
      cbus_cdata = wd[i];
      clks(2);
      cbus_sclk = 1'b1;
      clks(2);
    end
    cbus_sclk = 1'b0;
    clks(2);
    cbus_csn_n = 1'b1;
    clks(3);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    logic o;
    xfer(a, d, 16, dummy, o);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp,
                       input logic exp_oe);
    logic [15:0] got;
    logic o;
    xfer(a, 16'h0000, 16, got, o);
    chk(got, exp, "read data");
    chk({15'h0, o}, {15'h0, exp_oe}, "reply enable");
  endtask : rdchk

  task automatic wait_por;
    n = 0;
    while (por_active !== 1'b0 && n < 400) begin
      n++;
      clks(1);
    end
  endtask : wait_por

  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    cbus_csn_n = 1'b1;
    cbus_sclk = 1'b0;
    cbus_cdata = 1'b0;
    lvl = '{8'h12, 8'h34, 8'h56, 8'h50};
    clks(5);
    chk({15'h0, por_active}, 16'h0001, "por during reset");
    chk(power_ctl, 16'h0002, "sleep power");
    chk({15'h0, host_interrupt_n}, 16'h0001, "irq idle");
    reset_n = 1'b1;
    wait_por();
    chk({15'h0, (n >= 255 && n <= 257)}, 16'h0001, "por length");
    rdchk(8'hb2, 16'h0000, 1'b0);
    wr(8'hc0, 16'h0007);
    chk(power_ctl, 16'h0007, "monitor power");
    for (int s = 0; s < 4; s++) begin
      wr(8'hb2, 16'(s));
      clks(300);
      rdchk(8'hb4, {8'h00, lvl[s]}, 1'b1);
      chk(16'(adc_src_sel), 16'(s), "source select");
    end
    // high crossing, once only
    wr(8'hb3, 16'h8020);
    wr(8'hb2, 16'h0007);
    clks(300);
    rdchk(8'hc6, 16'h0000, 1'b1);
    lvl[3] = 8'h90;
    clks(300);
    chk({15'h0, host_interrupt_n}, 16'h0000, "high irq");
    rdchk(8'hc6, 16'h0001, 1'b1);
    clks(300);
    chk({15'h0, host_interrupt_n}, 16'h0001, "no repeat irq");
    rdchk(8'hc6, 16'h0000, 1'b1);
    // low crossing masked, then enabled
    lvl[3] = 8'h10;
    clks(300);
    chk({15'h0, host_interrupt_n}, 16'h0001, "masked low");
    rdchk(8'hc6, 16'h0002, 1'b1);
    wr(8'hb2, 16'h000b);
    lvl[3] = 8'h90;
    clks(300);
    rdchk(8'hc6, 16'h0001, 1'b1);
    lvl[3] = 8'h10;
    clks(300);
    chk({15'h0, host_interrupt_n}, 16'h0000, "low irq");
    rdchk(8'hc6, 16'h0002, 1'b1);
    // wake into receive, then transmit
    wr(8'hb2, 16'h0013);
    clks(300);
    lvl[3] = 8'h90;
    clks(300);
    chk(power_ctl, 16'h000f, "wake rx");
    wr(8'hc0, 16'h0007);
    lvl[3] = 8'h10;
    wr(8'hb2, 16'h0033);
    clks(300);
    lvl[3] = 8'h90;
    clks(300);
    chk(power_ctl, 16'h0017, "wake tx");
    // clock off stops conversions, last result still readable
    wr(8'hc0, 16'h0005);
    chk(power_ctl, 16'h0005, "xtal off by command");
    lvl[3] = 8'h22;
    clks(300);
    rdchk(8'hb4, 16'h0090, 1'b1);
    // general reset command
    wr(8'hc0, 16'h001f);
    xfer(8'h01, 16'h0000, 0, rd, oe);
    chk({15'h0, por_active}, 16'h0001, "command reset");
    chk(power_ctl, 16'h0002, "sleep after command");
    wait_por();
    chk({15'h0, (n >= 240 && n <= 257)}, 16'h0001, "cmd por len");
    rdchk(8'hc6, 16'h0000, 1'b1);
    wr(8'hc0, 16'h0007);
    clks(300);
    rdchk(8'hb4, {8'h00, lvl[0]}, 1'b1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
